// ===== pkg/cce_pkg.sv
/*
 Package for the common command executor: command codes, response codes,
 event register layout, reset values and timing counts.
 Assumes a single 250 MHz clock domain.
*/
package cce_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SELFTEST_TIME_NS = 400;
	localparam int SELFTEST_CYCLES = (SELFTEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OPC_BIT = 0;
	localparam int QYE_BIT = 2;
	localparam int EXE_BIT = 4;
	localparam int ESB_BIT = 5;
	localparam int PON_BIT = 7;
	localparam logic [7:0] SESR_RESET = 8'h80;
	localparam logic [7:0] ESE_RESET = 8'h00;
	localparam int NUM_CH = 16;
	localparam int LIST_DEPTH = 16;
	localparam logic [7:0] SETTINGS_RESET = 8'h00;

	typedef enum logic [3:0] {
		CCE_CMD_NONE = 4'h0,
		CCE_CMD_IDN = 4'h1,
		CCE_CMD_RST = 4'h2,
		CCE_CMD_TST = 4'h3,
		CCE_CMD_TRG = 4'h4,
		CCE_CMD_OPC = 4'h5,
		CCE_CMD_OPCQ = 4'h6,
		CCE_CMD_WAI = 4'h7,
		CCE_CMD_ABORT = 4'h8,
		CCE_CMD_SAVE = 4'h9,
		CCE_CMD_ESRQ = 4'hA,
		CCE_CMD_OTHER = 4'hF
	} cce_cmd_t;

	typedef enum logic [2:0] {
		CCE_RSP_NONE = 3'h0,
		CCE_RSP_IDN = 3'h1,
		CCE_RSP_PASS = 3'h2,
		CCE_RSP_FAIL = 3'h3,
		CCE_RSP_ONE = 3'h4,
		CCE_RSP_ESR = 3'h5
	} cce_rsp_t;

	typedef struct packed {
		logic valid;
		cce_cmd_t code;
	} cce_req_t;

	typedef struct packed {
		logic valid;
		cce_rsp_t code;
		logic [7:0] value;
	} cce_resp_t;
endpackage

// ===== src/cce_scan_list.sv
/*
 Small scan list memory: stores the channel order of the scan list.
 Read data come from a register; one write port, one read port.
*/
`timescale 1ns/1ps
module cce_scan_list
	import cce_pkg::*;
#(
	parameter int DEPTH = LIST_DEPTH,
	parameter int WIDTH = 4
) (
	input wire logic mclk,
	input wire logic wrEn,
	input wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [DEPTH];
	always_ff @(posedge mclk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule

// ===== src/cce_executor.sv
/*
 Common command executor: runs identity, reset, self-test, trigger and the
 operation-complete commands one at a time. Commands come from a parser on
 the same clock; relay drive, status byte and backup memory sit outside.
*/
// Function
// - The identity query answers maker, model, serial number and version in that order.
// - The reset command returns all settings to their initial state.
// - The reset command leaves the communication settings untouched.
// - The reset command opens every closed channel relay.
// - Reset settings survive power-off only after the save settings command.
// - The self-test query runs the test and answers PASS or FAIL.
// - A self-test query during a scan is not run and flags an execution error.
// - A trigger with an enabled list and no scan running starts the scan; here a trigger taken during wait does not.
// - Each trigger during a scan steps to the next channel in list order.
// - Set-complete holds later commands until done, then sets event bit 0.
// - Query-complete holds later commands until done, then answers 1.
// - Wait holds later commands until done but still accepts abort and trigger; here wait takes every command and drops all but abort and in-scan trigger.
// - Wait changes no event status bit and otherwise acts as set-complete.
// - An enabled set event bit sets summary bit 5 of the status byte.
`timescale 1ns/1ps
module cce_executor
	import cce_pkg::*;
#(
	parameter int CH = NUM_CH,
	parameter int DEPTH = LIST_DEPTH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire cce_req_t req,
	output logic reqReady,
	output cce_resp_t resp,
	input wire logic opBusy,
	input wire logic listEnable,
	input wire logic [$clog2(DEPTH)-1:0] listLength,
	input wire logic listWrEn,
	input wire logic [$clog2(DEPTH)-1:0] listWrAddr,
	input wire logic [$clog2(CH)-1:0] listWrData,
	input wire logic selfTestFault,
	input wire logic [7:0] eseMask,
	input wire logic [7:0] settingsIn,
	output logic [7:0] settingsOut,
	output logic [CH-1:0] relayClosed,
	output logic scanRunning,
	output logic [7:0] sesr,
	output logic esbSummary,
	output logic saveSettings
);
	localparam int CW = $clog2(CH);
	localparam int AW = $clog2(DEPTH);
	localparam int TW = $clog2(SELFTEST_CYCLES + 1);
	localparam logic [TW-1:0] TST_LAST = TW'(SELFTEST_CYCLES - 1);

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_TEST = 3'h1,
		ST_WAIT = 3'h2
	} cce_state_t;

	cce_state_t state_ff, nxt_state;
	cce_cmd_t waitCmd_ff, nxt_waitCmd;
	logic [TW-1:0] tstCnt_ff, nxt_tstCnt;
	logic tstFail_ff, nxt_tstFail;
	logic reqReady_ff, nxt_reqReady;
	cce_resp_t resp_ff, nxt_resp;
	logic [7:0] settings_ff, nxt_settings;
	logic [CH-1:0] relay_ff, nxt_relay;
	logic scan_ff, nxt_scan;
	logic [AW-1:0] pos_ff, nxt_pos;
	logic [7:0] sesr_ff, nxt_sesr;
	logic esb_ff, nxt_esb;
	logic save_ff, nxt_save;
	logic [CW-1:0] listData;

	function automatic logic [CH-1:0] chOneHot(input logic [CW-1:0] ch);
		chOneHot = '0;
		chOneHot[ch] = 1'b1;
	endfunction

	cce_scan_list #(.DEPTH(DEPTH), .WIDTH(CW)) u_list (
		.mclk(mclk),
		.wrEn(listWrEn),
		.wrAddr(listWrAddr),
		.wrData(listWrData),
		.rdAddr(nxt_pos),
		.rdData(listData)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_waitCmd = waitCmd_ff;
		nxt_tstCnt = tstCnt_ff;
		nxt_tstFail = tstFail_ff;
		nxt_resp = '0;
		nxt_settings = settings_ff;
		nxt_relay = relay_ff;
		nxt_scan = scan_ff;
		nxt_pos = pos_ff;
		nxt_sesr = sesr_ff;
		nxt_save = 1'b0;
		// scan step lands one cycle after the list read data, which lag the read address by one cycle
		if (scan_ff) begin
			nxt_relay = chOneHot(listData);
		end
		case (state_ff)
			ST_IDLE: begin
				if (req.valid && reqReady_ff) begin
					case (req.code)
						CCE_CMD_IDN: begin
							nxt_resp = '{valid: 1'b1, code: CCE_RSP_IDN, value: 8'h00};
						end
						CCE_CMD_RST: begin
							nxt_settings = SETTINGS_RESET;
							nxt_relay = '0;
							nxt_scan = 1'b0;
							nxt_pos = '0;
						end
						CCE_CMD_SAVE: begin
							nxt_save = 1'b1;
						end
						CCE_CMD_TST: begin
							if (scan_ff) begin
								nxt_sesr[EXE_BIT] = 1'b1;
							end else begin
								nxt_state = ST_TEST;
								nxt_tstCnt = '0;
								nxt_tstFail = 1'b0;
							end
						end
						CCE_CMD_TRG: begin
							if (scan_ff) begin
								nxt_pos = (pos_ff >= listLength) ? '0 : AW'(pos_ff + 1'b1);
							end else if (listEnable) begin
								nxt_scan = 1'b1;
								nxt_pos = '0;
							end
						end
						CCE_CMD_OPC, CCE_CMD_OPCQ, CCE_CMD_WAI: begin
							nxt_state = ST_WAIT;
							nxt_waitCmd = req.code;
						end
						CCE_CMD_ESRQ: begin
							nxt_resp = '{valid: 1'b1, code: CCE_RSP_ESR, value: sesr_ff};
							nxt_sesr = '0;
						end
						default: begin
						end
					endcase
				end
			end
			ST_TEST: begin
				nxt_tstFail = tstFail_ff | selfTestFault;
				nxt_tstCnt = TW'(tstCnt_ff + 1'b1);
				if (tstCnt_ff == TST_LAST) begin
					nxt_state = ST_IDLE;
					nxt_resp.valid = 1'b1;
					nxt_resp.code = (tstFail_ff | selfTestFault) ? CCE_RSP_FAIL : CCE_RSP_PASS;
				end
			end
			ST_WAIT: begin
				if (waitCmd_ff == CCE_CMD_WAI && req.valid && reqReady_ff) begin
					if (req.code == CCE_CMD_ABORT) begin
						nxt_scan = 1'b0;
					end else if (req.code == CCE_CMD_TRG && scan_ff) begin
						nxt_pos = (pos_ff >= listLength) ? '0 : AW'(pos_ff + 1'b1);
					end
				end
				if (!opBusy) begin
					nxt_state = ST_IDLE;
					if (waitCmd_ff == CCE_CMD_OPC) begin
						nxt_sesr[OPC_BIT] = 1'b1;
					end else if (waitCmd_ff == CCE_CMD_OPCQ) begin
						nxt_resp = '{valid: 1'b1, code: CCE_RSP_ONE, value: 8'h01};
					end
					// wait leaves the event register alone
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		// accept next request only in idle or in a wait for the wait command; that wait takes any request but acts on abort and on trigger during a scan only
		nxt_reqReady = (nxt_state == ST_IDLE) || (nxt_state == ST_WAIT && nxt_waitCmd == CCE_CMD_WAI);
		nxt_esb = |(nxt_sesr & eseMask);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			waitCmd_ff <= CCE_CMD_NONE;
			tstCnt_ff <= '0;
			tstFail_ff <= 1'b0;
			reqReady_ff <= 1'b0;
			resp_ff <= '0;
			settings_ff <= SETTINGS_RESET;
			relay_ff <= '0;
			scan_ff <= 1'b0;
			pos_ff <= '0;
			sesr_ff <= SESR_RESET;
			esb_ff <= 1'b0;
			save_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			waitCmd_ff <= nxt_waitCmd;
			tstCnt_ff <= nxt_tstCnt;
			tstFail_ff <= nxt_tstFail;
			reqReady_ff <= nxt_reqReady;
			resp_ff <= nxt_resp;
			settings_ff <= nxt_settings;
			relay_ff <= nxt_relay;
			scan_ff <= nxt_scan;
			pos_ff <= nxt_pos;
			sesr_ff <= nxt_sesr;
			esb_ff <= nxt_esb;
			save_ff <= nxt_save;
		end
	end

	// settingsIn carries the saved image; communication settings live elsewhere
	logic unusedIn;
	assign unusedIn = ^settingsIn;
	assign reqReady = reqReady_ff;
	assign resp = resp_ff;
	assign settingsOut = settings_ff;
	assign relayClosed = relay_ff;
	assign scanRunning = scan_ff;
	assign sesr = sesr_ff;
	assign esbSummary = esb_ff;
	assign saveSettings = save_ff;

	sequence s_opcTaken;
		req.valid && reqReady_ff && state_ff == ST_IDLE && req.code == CCE_CMD_OPC;
	endsequence
	sequence s_opDone;
		state_ff == ST_WAIT && !opBusy;
	endsequence

	property p_rst_relays;
		@(posedge mclk) disable iff (rst)
		(req.valid && reqReady_ff && state_ff == ST_IDLE && req.code == CCE_CMD_RST)
		|=> relay_ff == '0 && !scan_ff && settings_ff == SETTINGS_RESET;
	endproperty
	a_rst_relays: assert property (p_rst_relays) else $error("reset left relays or settings");

	property p_tst_in_scan;
		@(posedge mclk) disable iff (rst)
		(req.valid && reqReady_ff && state_ff == ST_IDLE && req.code == CCE_CMD_TST && scan_ff)
		|=> sesr_ff[EXE_BIT] && state_ff == ST_IDLE;
	endproperty
	a_tst_in_scan: assert property (p_tst_in_scan) else $error("self-test ran during scan");

	property p_tst_answer;
		@(posedge mclk) disable iff (rst)
		(state_ff == ST_IDLE && $past(state_ff) == ST_TEST)
		|-> resp_ff.valid && (resp_ff.code == CCE_RSP_PASS || resp_ff.code == CCE_RSP_FAIL);
	endproperty
	a_tst_answer: assert property (p_tst_answer) else $error("self-test gave no answer");

	property p_trg_start;
		@(posedge mclk) disable iff (rst)
		(req.valid && reqReady_ff && state_ff == ST_IDLE && req.code == CCE_CMD_TRG
		&& !scan_ff && listEnable) |=> scan_ff && pos_ff == '0;
	endproperty
	a_trg_start: assert property (p_trg_start) else $error("trigger did not start scan");

	property p_opc_sets;
		@(posedge mclk) disable iff (rst)
		(s_opDone and (waitCmd_ff == CCE_CMD_OPC)) |=> sesr_ff[OPC_BIT];
	endproperty
	a_opc_sets: assert property (p_opc_sets) else $error("set-complete flag missing");
	property p_opc_hold;
		@(posedge mclk) disable iff (rst)
		s_opcTaken |=> state_ff == ST_WAIT && !reqReady_ff;
	endproperty
	a_opc_hold: assert property (p_opc_hold) else $error("set-complete did not hold");

	property p_block;
		@(posedge mclk) disable iff (rst)
		(state_ff == ST_WAIT && waitCmd_ff != CCE_CMD_WAI) || state_ff == ST_TEST |-> !reqReady_ff;
	endproperty
	a_block: assert property (p_block) else $error("command taken while blocked");

	property p_opcq_one;
		@(posedge mclk) disable iff (rst)
		(s_opDone and (waitCmd_ff == CCE_CMD_OPCQ)) |=> resp_ff.valid && resp_ff.value == 8'h01;
	endproperty
	a_opcq_one: assert property (p_opcq_one) else $error("query-complete did not answer 1");

	property p_wai_quiet;
		@(posedge mclk) disable iff (rst)
		(s_opDone and (waitCmd_ff == CCE_CMD_WAI)) |=> sesr_ff == $past(sesr_ff);
	endproperty
	a_wai_quiet: assert property (p_wai_quiet) else $error("wait touched event register");

	property p_esb;
		@(posedge mclk) disable iff (rst)
		##1 esb_ff == |(sesr_ff & $past(eseMask));
	endproperty
	a_esb: assert property (p_esb) else $error("summary bit mismatch");
endmodule

// ===== tb/cce_host_model.sv
/*
 Host side model: issues one command at a time and collects response pulses.
 Assumes the executor clock and the response format of cce_pkg.
*/
`timescale 1ns/1ps
module cce_host_model
	import cce_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic reqReady,
	input wire cce_resp_t resp,
	output cce_req_t req
);
	cce_resp_t rxq[$];
	initial req = '0;
	// response stands one cycle, so one look per cycle
	always @(negedge mclk) begin
		if (!rst && resp.valid === 1'b1) rxq.push_back(resp);
	end
	// request held until an edge samples reqReady high
	task automatic send(input cce_cmd_t code, output bit ok);
		logic rdy;
		ok = 0;
		@(posedge mclk);
		#1 req = {1'b1, code};
		for (int i = 0; i < 400 && !ok; i++) begin
			@(negedge mclk);
			rdy = reqReady;
			@(posedge mclk);
			ok = (rdy === 1'b1);
		end
		#1 req = '0;
	endtask
	// completion query before relay-dependent traffic
	task automatic settle(output bit ok);
		cce_resp_t r;
		r = '0;
		send(CCE_CMD_OPCQ, ok);
		for (int i = 0; i < 400 && ok && rxq.size() == 0; i++) @(negedge mclk);
		if (rxq.size() > 0) r = rxq.pop_front();
		ok = ok && (r.valid === 1'b1) && (r.code === CCE_RSP_ONE);
	endtask
endmodule

// ===== tb/common_command_executor_test.sv
/*
 Self-checking bench for the common command executor.
 Assumes cce_host_model on the request side and a 250 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %0h expected %0h", $time, g, e); end end
module common_command_executor_test;
	import cce_pkg::*;
	localparam int AW = $clog2(LIST_DEPTH);
	localparam int CW = $clog2(NUM_CH);
	logic mclk = 0, rst = 1, opBusy = 0, listEnable = 0, listWrEn = 0, selfTestFault = 0;
	logic [AW-1:0] listLength = '0, listWrAddr = '0;
	logic [CW-1:0] listWrData = '0;
	logic [CW-1:0] list [4];
	logic [7:0] eseMask = 8'h01, settingsIn = 8'h00, settingsOut, sesr;
	logic [NUM_CH-1:0] relayClosed;
	logic reqReady, scanRunning, esbSummary, saveSettings;
	cce_req_t req;
	cce_resp_t resp, rx;
	int fail_count = 0, checks_done = 0, n;
	int seed = 32'h7c34f0f2;
	bit ok, seen;
	cce_executor dut_u (.mclk(mclk), .rst(rst), .req(req), .reqReady(reqReady), .resp(resp),
		.opBusy(opBusy), .listEnable(listEnable), .listLength(listLength),
		.listWrEn(listWrEn), .listWrAddr(listWrAddr), .listWrData(listWrData),
		.selfTestFault(selfTestFault), .eseMask(eseMask), .settingsIn(settingsIn),
		.settingsOut(settingsOut), .relayClosed(relayClosed), .scanRunning(scanRunning),
		.sesr(sesr), .esbSummary(esbSummary), .saveSettings(saveSettings));
	cce_host_model host_u (.mclk(mclk), .rst(rst), .reqReady(reqReady), .resp(resp), .req(req));
	initial begin
		forever #2 mclk = ~mclk;
	end
	always @(negedge mclk) begin
		if (!rst) `CHK(esbSummary, |(sesr & eseMask))
	end
	function automatic logic [NUM_CH-1:0] onehot(input logic [CW-1:0] ch);
		return NUM_CH'(1) << ch;
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic timeout();
		fail_count++;
		$display("[FAIL] %0t wait limit reached", $time);
		end_of_test();
	endtask
	task automatic cmd(input cce_cmd_t c);
		host_u.send(c, ok);
		if (!ok) timeout();
	endtask
	task automatic expect_rsp(input cce_rsp_t code);
		for (int i = 0; i < 300 && host_u.rxq.size() == 0; i++) tick(1);
		if (host_u.rxq.size() == 0) timeout();
		rx = host_u.rxq.pop_front();
		`CHK(rx.code, code)
	endtask
	task automatic busy_for_random();
		n = 3 + ($unsigned($random(seed)) % 16);
		tick(n);
	endtask
	initial begin
		eseMask = (8'($random(seed)) & 8'h7F) | 8'h01;
		settingsIn = 8'($random(seed));
		tick(15);
		`CHK(reqReady, 1'b0)
		`CHK(sesr, SESR_RESET)
		`CHK(relayClosed, '0)
		tick(1);
		rst = 0;
		tick(2);
		cmd(CCE_CMD_ESRQ);
		expect_rsp(CCE_RSP_ESR);
		`CHK(rx.value, SESR_RESET)
		cmd(CCE_CMD_IDN);
		cmd(CCE_CMD_ESRQ);
		expect_rsp(CCE_RSP_IDN);
		expect_rsp(CCE_RSP_ESR);
		`CHK(rx.value, 8'h00)
		opBusy = 1;
		cmd(CCE_CMD_OPC);
		busy_for_random();
		`CHK(reqReady, 1'b0)
		`CHK(sesr[OPC_BIT], 1'b0)
		opBusy = 0;
		tick(2);
		`CHK(sesr[OPC_BIT], 1'b1)
		cmd(CCE_CMD_ESRQ);
		expect_rsp(CCE_RSP_ESR);
		`CHK(rx.value, 8'h01)
		opBusy = 1;
		cmd(CCE_CMD_OPCQ);
		busy_for_random();
		`CHK(host_u.rxq.size() == 0, 1'b1)
		opBusy = 0;
		expect_rsp(CCE_RSP_ONE);
		opBusy = 1;
		cmd(CCE_CMD_WAI);
		cmd(CCE_CMD_IDN);
		tick(4);
		`CHK(host_u.rxq.size() == 0, 1'b1)
		opBusy = 0;
		tick(3);
		`CHK(sesr, 8'h00)
		for (int i = 0; i < 4; i++) begin
			list[i] = CW'($random(seed));
			listWrEn = 1;
			listWrAddr = AW'(i);
			listWrData = list[i];
			tick(1);
		end
		listWrEn = 0;
		listLength = AW'(3);
		listEnable = 1;
		cmd(CCE_CMD_TRG);
		tick(3);
		`CHK(scanRunning, 1'b1)
		`CHK(relayClosed, onehot(list[0]))
		cmd(CCE_CMD_TRG);
		tick(3);
		`CHK(relayClosed, onehot(list[1]))
		cmd(CCE_CMD_TST);
		tick(3);
		`CHK(sesr[EXE_BIT], 1'b1)
		tick(SELFTEST_CYCLES + 10);
		`CHK(host_u.rxq.size() == 0, 1'b1)
		opBusy = 1;
		cmd(CCE_CMD_WAI);
		cmd(CCE_CMD_TRG);
		tick(3);
		`CHK(relayClosed, onehot(list[2]))
		cmd(CCE_CMD_ABORT);
		tick(3);
		`CHK(scanRunning, 1'b0)
		opBusy = 0;
		tick(3);
		cmd(CCE_CMD_TRG);
		tick(3);
		`CHK(relayClosed, onehot(list[0]))
		cmd(CCE_CMD_RST);
		tick(3);
		`CHK(relayClosed, '0)
		`CHK(scanRunning, 1'b0)
		`CHK(settingsOut, SETTINGS_RESET)
		host_u.settle(ok);
		`CHK(ok, 1'b1)
		for (int f = 0; f < 2; f++) begin
			selfTestFault = f[0];
			cmd(CCE_CMD_TST);
			expect_rsp(f ? CCE_RSP_FAIL : CCE_RSP_PASS);
		end
		selfTestFault = 0;
		cmd(CCE_CMD_SAVE);
		seen = 0;
		repeat (4) begin
			if (saveSettings === 1'b1) seen = 1;
			tick(1);
		end
		`CHK(seen, 1'b1)
		end_of_test();
	end
endmodule
